// ==== smc_config_timeouts.sv ====
// smbus configuration register, bus watch, timeouts and pin timing
// Functional notes
// - With enable set the interface watches SDA and SCL continuously.
// - With slave inhibit set at a START no slave interrupt is raised until the next START.
// - Slave inhibit leaves master interrupts untouched.
// - Busy is set by hardware while a transfer is on the bus.
// - Busy clears on a STOP or on bus-free timeout expiry.
// - Extension bit chooses normal or extended SDA setup and hold.
// - SCL timeout enable reloads Timer 3 on SCL high, counts on SCL low.
// - In split mode only the Timer 3 high byte is held in reload.
// - Free timeout: bus free after both lines high over 10 source periods.
// - Clock select: 00 T0, 01 T1, 10 T2 high byte, 11 T2 low byte.
// - As master each SCL phase lasts at least one source overflow period.
// - Extended: SDA stable 11 clocks before SCL rise, 12 after SCL fall.
// - A pending master START is issued right after the free timeout.
// - Inhibited slave still watches, NACKs addresses, raises no irq.
`default_nettype none
module smc_config_timeouts (
  input wire logic mclk,
  input wire logic reset,
  input wire smc_pkg::smc_sfr_t sfr,
  output logic [7:0] bus_config_rdata,
  input wire smc_pkg::smc_ovf_t ovf,
  input wire logic t3_split,
  output logic t3_reload_low,
  output logic t3_reload_high,
  input wire smc_pkg::smc_eng_t eng,
  output logic bit_clk_tick,
  output logic scl_phase_ok,
  output logic free_timeout,
  output logic start_go,
  output logic start_det,
  output logic stop_det,
  output logic smb_irq,
  output logic addr_ack_out,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe_n,
  output logic sda_out,
  output logic sda_oe_n
);
  import smc_pkg::*;

  typedef struct packed {
    smc_cfg_t cfg;
    logic scl_d;
    logic sda_d;
    logic [3:0] free_cnt;
    logic free_done;
    logic [3:0] phase_cnt;
    logic [3:0] setup_cnt;
    logic [3:0] hold_cnt;
    logic sda_drv;
    logic scl_drv;
    logic inh_active;
    logic start_p;
    logic stop_p;
    logic free_p;
  } smc_st_t;

  smc_st_t st_reg;
  smc_st_t st_next;
  logic scl_s;
  logic sda_s;
  logic tick;
  logic scl_rise;
  logic scl_fall;
  logic sda_want;
  logic [3:0] setup_need;
  logic [3:0] hold_need;

  // pin levels cross into mclk through two stages each
  smc_sync u_scl_sync (
    .mclk(mclk),
    .reset(reset),
    .din(scl_in),
    .dout(scl_s)
  );
  smc_sync u_sda_sync (
    .mclk(mclk),
    .reset(reset),
    .din(sda_in),
    .dout(sda_s)
  );

  // overflow source select
  always_comb begin
    case (st_reg.cfg.bit_clock_select)
      SMC_SRC_T0: tick = ovf.t0_ovf;
      SMC_SRC_T1: tick = ovf.t1_ovf;
      SMC_SRC_T2H: tick = ovf.t2h_ovf;
      SMC_SRC_T2L: tick = ovf.t2l_ovf;
      default: tick = 1'b0;
    endcase
  end

  // sda setup and hold targets per extension bit
  always_comb begin
    if (st_reg.cfg.sda_time_extend) begin
      setup_need = SETUP_EXT_CLKS;
      hold_need = HOLD_EXT_CLKS;
    end else begin
      setup_need = SETUP_NORM_CLKS;
      hold_need = HOLD_NORM_CLKS;
    end
  end

  assign scl_rise = st_reg.cfg.iface_enable && scl_s && !st_reg.scl_d;
  assign scl_fall = st_reg.cfg.iface_enable && !scl_s && st_reg.scl_d;
  assign sda_want = eng.sda_drive_low && st_reg.cfg.iface_enable;

  // whole state update
  always_comb begin
    st_next = st_reg;
    st_next.scl_d = scl_s;
    st_next.sda_d = sda_s;
    st_next.start_p = 1'b0;
    st_next.stop_p = 1'b0;
    st_next.free_p = 1'b0;
    // register write, busy kept by hardware
    if (sfr.wr && sfr.addr == BUS_CONFIG_ADDR) begin
      st_next.cfg = sfr.wdata;
      st_next.cfg.busy = st_reg.cfg.busy;
    end
    if (st_reg.cfg.iface_enable) begin
      // start and stop seen while enabled
      if (st_reg.scl_d && scl_s && st_reg.sda_d && !sda_s) begin
        st_next.start_p = 1'b1;
        st_next.cfg.busy = 1'b1;
        st_next.inh_active = st_reg.cfg.slave_inhibit;
      end
      if (st_reg.scl_d && scl_s && !st_reg.sda_d && sda_s) begin
        st_next.stop_p = 1'b1;
        st_next.cfg.busy = 1'b0;
      end
      if (!scl_s || !sda_s) begin
        st_next.cfg.busy = !(st_reg.scl_d && scl_s && !st_reg.sda_d && sda_s)
          ? 1'b1 : 1'b0;
      end
      // bus free timeout over both lines high
      if (!(scl_s && sda_s) || !st_reg.cfg.bus_free_timeout_en) begin
        st_next.free_cnt = 4'h0;
        st_next.free_done = 1'b0;
      end else if (tick && !st_reg.free_done) begin
        if (st_reg.free_cnt == FREE_LIMIT) begin
          st_next.free_done = 1'b1;
          st_next.free_p = 1'b1;
          st_next.cfg.busy = 1'b0;
        end else begin
          st_next.free_cnt = st_reg.free_cnt + 4'h1;
        end
      end
      // scl phase length counted in source ticks
      if (scl_rise || scl_fall) begin
        st_next.phase_cnt = 4'h0;
      end else if (tick && st_reg.phase_cnt != 4'hF) begin
        st_next.phase_cnt = st_reg.phase_cnt + 4'h1;
      end
      // sda changes wait out hold after scl fall
      if (scl_fall) begin
        st_next.hold_cnt = 4'h0;
      end else if (st_reg.hold_cnt != 4'hF) begin
        st_next.hold_cnt = st_reg.hold_cnt + 4'h1;
      end
      if (sda_want != st_reg.sda_drv && st_reg.hold_cnt >= hold_need) begin
        st_next.sda_drv = sda_want;
        st_next.setup_cnt = 4'h0;
      end else if (st_reg.setup_cnt != 4'hF) begin
        st_next.setup_cnt = st_reg.setup_cnt + 4'h1;
      end
      // scl release waits for phase length and sda setup
      if (eng.scl_drive_low) begin
        if (!st_reg.scl_drv && st_reg.phase_cnt != 4'h0) begin
          st_next.scl_drv = 1'b1;
        end
      end else if (st_reg.scl_drv && st_reg.phase_cnt != 4'h0
          && st_reg.setup_cnt >= setup_need) begin
        st_next.scl_drv = 1'b0;
      end
    end else begin
      // disabled: lines released, counters idle
      st_next.sda_drv = 1'b0;
      st_next.scl_drv = 1'b0;
      st_next.free_cnt = 4'h0;
      st_next.free_done = 1'b0;
      st_next.phase_cnt = PHASE_RESET;
      st_next.hold_cnt = 4'hF;
      st_next.setup_cnt = 4'hF;
      st_next.cfg.busy = 1'b0;
    end
    if (reset) begin
      st_next = '0;
      st_next.cfg = BUS_CONFIG_RESET;
      st_next.scl_d = 1'b1;
      st_next.sda_d = 1'b1;
      st_next.hold_cnt = 4'hF;
      st_next.setup_cnt = 4'hF;
    end
  end

  always_ff @(posedge mclk) begin
    st_reg <= st_next;
  end

  // register readback and event outputs
  assign bus_config_rdata = st_reg.cfg;
  assign bit_clk_tick = tick && st_reg.cfg.iface_enable;
  assign scl_phase_ok = st_reg.phase_cnt != 4'h0;
  assign free_timeout = st_reg.free_p;
  assign start_det = st_reg.start_p;
  assign stop_det = st_reg.stop_p;
  assign start_go = st_reg.free_p && eng.start_req;

  // interrupt gating, master passes whenever enabled
  assign smb_irq = st_reg.cfg.iface_enable
    && (eng.master_irq
    || (eng.slave_irq && !st_reg.inh_active));
  assign addr_ack_out = eng.slave_addr_ack && !st_reg.inh_active
    && st_reg.cfg.iface_enable;

  // timer 3 reload while scl high
  assign t3_reload_high = st_reg.cfg.iface_enable
    && st_reg.cfg.scl_low_timeout_en && scl_s;
  assign t3_reload_low = t3_reload_high && !t3_split;

  // open-drain pins, enable low while pulling low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_n = !st_reg.scl_drv;
  assign sda_oe_n = !st_reg.sda_drv;
endmodule : smc_config_timeouts
`default_nettype wire

// ==== smc_pkg.sv ====
// package for the smbus configuration and timeout slice
`default_nettype none
package smc_pkg;
  localparam logic [7:0] BUS_CONFIG_ADDR = 8'hC1;
  localparam logic [7:0] BUS_CONFIG_RESET = 8'h00;
  localparam int BIT_ENABLE = 7;
  localparam int BIT_INHIBIT = 6;
  localparam int BIT_BUSY = 5;
  localparam int BIT_EXTEND = 4;
  localparam int BIT_SCL_TO = 3;
  localparam int BIT_FREE_TO = 2;
  localparam int FREE_PERIODS = 10;
  localparam logic [3:0] FREE_LIMIT = 4'hA;
  localparam logic [3:0] SETUP_EXT_CLKS = 4'hB;
  localparam logic [3:0] HOLD_EXT_CLKS = 4'hC;
  localparam logic [3:0] HOLD_NORM_CLKS = 4'h3;
  localparam logic [3:0] SETUP_NORM_CLKS = 4'h1;
  localparam logic [1:0] SYNC_RESET = 2'h3;
  localparam logic [3:0] PHASE_RESET = 4'h0;

  typedef enum logic [1:0] {
    SMC_SRC_T0 = 2'b00,
    SMC_SRC_T1 = 2'b01,
    SMC_SRC_T2H = 2'b10,
    SMC_SRC_T2L = 2'b11
  } smc_src_t;

  // configuration fields of the register
  typedef struct packed {
    logic iface_enable;
    logic slave_inhibit;
    logic busy;
    logic sda_time_extend;
    logic scl_low_timeout_en;
    logic bus_free_timeout_en;
    smc_src_t bit_clock_select;
  } smc_cfg_t;

  // register port bundle
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
  } smc_sfr_t;

  // timer overflow inputs
  typedef struct packed {
    logic t0_ovf;
    logic t1_ovf;
    logic t2h_ovf;
    logic t2l_ovf;
  } smc_ovf_t;

  // events to and from the transfer engine
  typedef struct packed {
    logic start_req;
    logic scl_drive_low;
    logic sda_drive_low;
    logic master_irq;
    logic slave_irq;
    logic slave_addr_ack;
  } smc_eng_t;
endpackage : smc_pkg
`default_nettype wire

// ==== smc_sync.sv ====
// two flip-flop synchroniser for one pin level
`default_nettype none
module smc_sync (
  input wire logic mclk,
  input wire logic reset,
  input wire logic din,
  output logic dout
);
  import smc_pkg::*;
  typedef struct packed {
    logic [1:0] ff;
  } smc_sync_st_t;
  smc_sync_st_t st_reg;
  smc_sync_st_t st_next;

  // shift the pin through two stages, released bus idles high
  always_comb begin
    st_next = st_reg;
    st_next.ff = {st_reg.ff[0], din};
    if (reset) begin
      st_next.ff = SYNC_RESET;
    end
  end

  always_ff @(posedge mclk) begin
    st_reg <= st_next;
  end

  assign dout = st_reg.ff[1];
endmodule : smc_sync
`default_nettype wire

// ==== smc_chk.sv ====
// assertion checker for the smbus configuration slice
`default_nettype none
module smc_chk (
  input wire logic mclk,
  input wire logic reset,
  input wire smc_pkg::smc_sfr_t sfr,
  input wire logic [7:0] bus_config_rdata,
  input wire smc_pkg::smc_ovf_t ovf,
  input wire logic t3_split,
  input wire logic t3_reload_low,
  input wire logic t3_reload_high,
  input wire smc_pkg::smc_eng_t eng,
  input wire logic bit_clk_tick,
  input wire logic free_timeout,
  input wire logic start_go,
  input wire logic start_det,
  input wire logic stop_det,
  input wire logic scl_in,
  input wire logic scl_oe_n,
  input wire logic sda_oe_n
);
  import smc_pkg::*;
  logic [7:0] r;
  // short alias of the register contents
  assign r = bus_config_rdata;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  property p_reset;
    $fell(reset) |-> r == 8'h00;
  endproperty
  a_reset: assert property (p_reset) else $error("bad reset value");
  property p_write;
    sfr.wr && sfr.addr == BUS_CONFIG_ADDR |=>
      (r & 8'hDF) == ($past(sfr.wdata) & 8'hDF);
  endproperty
  a_write: assert property (p_write) else $error("bad write");
  property p_off;
    !r[7] && !$past(r[7]) |->
      scl_oe_n && sda_oe_n && !start_det && !stop_det && !free_timeout;
  endproperty
  a_off: assert property (p_off) else $error("active while off");
  property p_tick;
    bit_clk_tick == (r[7] && ovf[2'd3 - r[1:0]]);
  endproperty
  a_tick: assert property (p_tick) else $error("bad tick");
  property p_reload;
    (scl_in && r[7] && r[3])[*3] |->
      t3_reload_high && (t3_reload_low == !t3_split);
  endproperty
  a_reload: assert property (p_reload) else $error("no reload");
  property p_go;
    free_timeout && eng.start_req |-> start_go;
  endproperty
  a_go: assert property (p_go) else $error("start not issued");
  property p_clear;
    free_timeout || stop_det |-> ##[0:1] !r[5];
  endproperty
  a_clear: assert property (p_clear) else $error("busy kept");
  property p_set;
    start_det |-> ##[0:1] r[5];
  endproperty
  a_set: assert property (p_set) else $error("busy not set");
endmodule : smc_chk
bind smc_config_timeouts smc_chk u_smc_chk (.*);
`default_nettype wire

// ==== smc_bus_model.sv ====
// other bus parties on the two wires, with pull-ups
`default_nettype none
module smc_bus_model (
  input wire logic scl_out,
  input wire logic scl_oe_n,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic pull_scl,
  input wire logic pull_sda,
  output logic scl_in,
  output logic sda_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // wired-and; a released line floats high
  assign scl_in = !((!scl_oe_n && !scl_out) || pull_scl);
  assign sda_in = !((!sda_oe_n && !sda_out) || pull_sda);
endmodule : smc_bus_model
`default_nettype wire

// ==== smc_config_timeouts_bench.sv ====
// self-checking bench for the smbus configuration slice
`default_nettype none
module smc_config_timeouts_bench;
  import smc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [7:0] cfg;
    logic [3:0] ov;
    logic tick;
  } smc_row_t;
  logic mclk, reset, t3_split, pull_scl, pull_sda, rl, rh, tick, ft, go;
  logic sd, pd, irq, ack, scl_in, sda_in, scl_out, scl_oe_n, sda_out, sda_oe_n;
  logic [7:0] rd;
  logic po;
  smc_sfr_t sfr;
  smc_ovf_t ovf;
  smc_eng_t eng;
  int n_mismatch, samples_checked, n_free, n_go;
  smc_row_t rows [7] = '{'{8'h80, 4'h8, 1'b1}, '{8'h80, 4'h4, 1'b0},
    '{8'h81, 4'h4, 1'b1}, '{8'h82, 4'h2, 1'b1}, '{8'h83, 4'h1, 1'b1},
    '{8'h83, 4'h2, 1'b0}, '{8'h03, 4'h1, 1'b0}};
  smc_config_timeouts u_smc_config_timeouts (.mclk(mclk), .reset(reset),
    .sfr(sfr), .bus_config_rdata(rd), .ovf(ovf), .t3_split(t3_split),
    .t3_reload_low(rl), .t3_reload_high(rh), .eng(eng), .bit_clk_tick(tick),
    .scl_phase_ok(po), .free_timeout(ft), .start_go(go), .start_det(sd),
    .stop_det(pd), .smb_irq(irq), .addr_ack_out(ack), .scl_in(scl_in),
    .sda_in(sda_in), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n));
  smc_bus_model u_smc_bus_model (.scl_out(scl_out), .scl_oe_n(scl_oe_n),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .pull_scl(pull_scl),
    .pull_sda(pull_sda), .scl_in(scl_in), .sda_in(sda_in));
  // free-running system clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // count timeout and start pulses
  always @(posedge mclk) begin
    if (ft === 1'b1) n_free++;
    if (go === 1'b1) n_go++;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic stop_test();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) sfr <= '{a, d, 1'b1};
    @(posedge mclk) sfr.wr <= 1'b0;
    #1;
  endtask : wr
  // one half phase of the 1000 ns link clock
  task automatic line(input logic c, input logic d);
    @(posedge mclk) begin
      pull_scl <= !c;
      pull_sda <= !d;
    end
    repeat (4) @(posedge mclk);
    #1;
  endtask : line
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge mclk) ovf <= 4'h8;
      @(posedge mclk) ovf <= 4'h0;
      @(posedge mclk);
    end
  endtask : pulse
  // watchdog
  initial begin
    #300000;
    n_mismatch++;
    stop_test();
  end
  // main sequence
  initial begin
    {reset, t3_split, pull_scl, pull_sda} = 4'h8;
    sfr = '0;
    ovf = '0;
    eng = '0;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    #1;
    chk(rd, 8'h00);
    wr(8'hC1, 8'hFF);
    chk(rd, 8'hDF);
    wr(8'hC0, 8'h00);
    chk(rd, 8'hDF);
    foreach (rows[i]) begin
      wr(8'hC1, rows[i].cfg);
      @(posedge mclk) ovf <= rows[i].ov;
      #1;
      chk(tick, rows[i].tick);
      @(posedge mclk) ovf <= 4'h0;
    end
    wr(8'hC1, 8'h88);
    repeat (4) @(posedge mclk);
    #1;
    chk({rh, rl}, 2'b11);
    @(posedge mclk) t3_split <= 1'b1;
    #1;
    chk({rh, rl}, 2'b10);
    line(0, 1);
    chk(rh, 0);
    line(1, 1);
    wr(8'hC1, 8'hC4);
    line(1, 0);
    chk(rd[5], 1);
    @(posedge mclk) eng <= 6'h03;
    @(posedge mclk);
    #1;
    chk({irq, ack}, 2'b00);
    @(posedge mclk) eng <= 6'h04;
    @(posedge mclk);
    #1;
    chk(irq, 1);
    eng <= '0;
    line(0, 0);
    line(1, 0);
    line(1, 1);
    chk(rd[5], 0);
    line(0, 1);
    line(1, 1);
    chk(rd[5], 1);
    {n_free, n_go} = 0;
    @(posedge mclk) eng <= 6'h20;
    pulse(10);
    chk(n_free, 0);
    pulse(2);
    repeat (3) @(posedge mclk);
    #1;
    chk({n_free[3:0], n_go[3:0], rd[5]}, 9'h022);
    eng <= '0;
    wr(8'hC1, 8'h90);
    line(0, 1);
    @(posedge mclk) eng <= 6'h08;
    repeat (5) @(posedge mclk);
    #1;
    chk(sda_oe_n, 1);
    repeat (10) @(posedge mclk);
    #1;
    chk(sda_oe_n, 0);
    eng <= '0;
    line(0, 1);
    line(1, 1);
    wr(8'hC1, 8'h80);
    line(0, 1);
    @(posedge mclk) eng <= 6'h08;
    repeat (3) @(posedge mclk);
    #1;
    chk(sda_oe_n, 0);
    eng <= '0;
    line(0, 1);
    line(1, 1);
    // scl pulled only after a source tick since the last scl edge
    chk(po, 0);
    @(posedge mclk) eng <= 6'h10;
    repeat (3) @(posedge mclk);
    #1;
    chk(scl_oe_n, 1);
    pulse(1);
    repeat (2) @(posedge mclk);
    #1;
    chk({po, scl_oe_n}, 2'b10);
    eng <= '0;
    pulse(1);
    repeat (3) @(posedge mclk);
    #1;
    chk(scl_oe_n, 1);
    wr(8'hC1, 8'h00);
    line(1, 0);
    chk({rd, scl_oe_n, sda_oe_n}, 10'h003);
    line(1, 1);
    stop_test();
  end
endmodule : smc_config_timeouts_bench
`default_nettype wire
